/* File: pin_mux_params.svh */
// Constants for the port S, P, L and AD pin multiplexer
// Behaviour
// - Shared pin output goes to highest listed function, down to general-purpose port.
// - Port S pin 3: clock out, MOSI, routed transmit 1, routed PWM 5, routed trigger 1 input, port.
// - Port S pin 2: MISO, routed receive 1, routed PWM 4, routed trigger 0 input, port.
// - Port S pin 1: transmit 1, routed LIN bit, routed transmit 0, port.
// - Port S pin 0 feeds receive 1 or routed receive 0, else port.
// - Port P pin 5: maskable interrupt ahead of PWM 5; trigger 1, port.
// - Port P pin 4: PWM 4, then port; trigger 0 input.
// - Port P pin 2: PWM 2, then switchable supply output, then port.
// - Port P pin 1: nonmaskable interrupt before PWM 1; pin 0 PWM 0 before port.
// - Port L pins 3..0 are input-only high-voltage inputs; inputs after reset.
// - Port AD pins 5..0: analog input beats port use; port after reset.
// - Routed alternative claims its pin only when its routing option selects it.
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH
`define PORT_S_WIDTH 6
`define PORT_P_WIDTH 6
`define PORT_L_WIDTH 4
`define PORT_AD_WIDTH 6
`define PORT_RESET_VALUE 6'h00
`define PORT_L_RESET_VALUE 4'h0
`endif

/* File: pin_sync.sv */
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule

/* File: pin_mux_pkg.sv */
// Types for the port S, P, L and AD pin multiplexer
`include "pin_mux_params.svh"
package pin_mux_pkg;
    // Peripheral output requests into the multiplexer
    typedef struct packed {
        logic       free_running_clock_out_en;
        logic       free_running_clock_out;
        logic       spi_ss_en;
        logic       spi_ss_out;
        logic       spi_sck_en;
        logic       spi_sck_out;
        logic       spi_mosi_en;
        logic       spi_mosi_out;
        logic       spi_miso_en;
        logic       spi_miso_out;
        logic       serial_if1_transmit_en;
        logic       serial_if1_transmit;
        logic       serial_if0_transmit;
        logic       lin_transceiver_reg_bit_out;
        logic [5:0] pwm_en;
        logic [5:0] pwm_out;
        logic       switchable_supply_out_en;
        logic       irq_enable;
        logic       nonmaskable_interrupt_en;
    } periph_out_t;

    // Routing choices for alternative pins
    typedef struct packed {
        logic serial_if1_to_s3_s2;
        logic pulse_width_channel_5_to_s3;
        logic pulse_width_channel_4_to_s2;
        logic trig1_from_s3;
        logic trig0_from_s2;
        logic lin_bit_to_s1;
        logic serial_if0_to_s1_s0;
        logic [3:0] port_l_adc_link;
    } routing_t;

    // General-purpose port settings
    typedef struct packed {
        logic [5:0] port_s_data;
        logic [5:0] port_s_dir;
        logic [5:0] port_p_data;
        logic [5:0] port_p_dir;
        logic [5:0] port_ad_data;
        logic [5:0] port_ad_dir;
        logic [5:0] analog_channel_en;
    } gpio_ctrl_t;

    // Synchronised inputs returned to peripherals
    typedef struct packed {
        logic       serial_if1_receive;
        logic       serial_if0_receive;
        logic       spi_miso_in;
        logic       spi_mosi_in;
        logic       spi_sck_in;
        logic       spi_ss_in;
        logic       adc_trigger_in_0;
        logic       adc_trigger_in_1;
        logic       irq_in;
        logic       nonmaskable_interrupt_in;
        logic [5:0] port_s_gpio;
        logic [5:0] port_p_gpio;
        logic [3:0] port_l_gpio;
        logic [5:0] port_ad_gpio;
        logic [3:0] high_voltage_input_adc;
    } periph_in_t;
endpackage

/* File: port_s_p_l_ad_pin_mux.sv */
// Output-priority pin multiplexer for ports S, P, L and AD
`timescale 1ns/10ps
`include "pin_mux_params.svh"
module port_s_p_l_ad_pin_mux
    import pin_mux_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire periph_out_t                 periph_out,
    input  wire routing_t                    routing,
    input  wire gpio_ctrl_t                  gpio_ctrl,
    input  wire logic [`PORT_S_WIDTH-1:0]    port_s_pin_in,
    input  wire logic [`PORT_P_WIDTH-1:0]    port_p_pin_in,
    input  wire logic [`PORT_L_WIDTH-1:0]    port_l_pin_in,
    input  wire logic [`PORT_AD_WIDTH-1:0]   port_ad_pin_in,
    output logic      [`PORT_S_WIDTH-1:0]    port_s_pin_out,
    output logic      [`PORT_S_WIDTH-1:0]    port_s_pin_oe,
    output logic      [`PORT_P_WIDTH-1:0]    port_p_pin_out,
    output logic      [`PORT_P_WIDTH-1:0]    port_p_pin_oe,
    output logic      [`PORT_AD_WIDTH-1:0]   port_ad_pin_out,
    output logic      [`PORT_AD_WIDTH-1:0]   port_ad_pin_oe,
    output logic      [`PORT_AD_WIDTH-1:0]   analog_channel_in_sel,
    output periph_in_t                       periph_in
);
    logic [5:0] s_sync;
    logic [5:0] p_sync;
    logic [3:0] l_sync;
    logic [5:0] ad_sync;
    logic [5:0] next_s_out;
    logic [5:0] next_s_oe;
    logic [5:0] next_p_out;
    logic [5:0] next_p_oe;

    // Pin inputs pass two flops first
    pin_sync #(
        .WIDTH    (`PORT_S_WIDTH)
    ) u_sync_s (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (port_s_pin_in),
        .sync_out (s_sync)
    );
    pin_sync #(
        .WIDTH    (`PORT_P_WIDTH)
    ) u_sync_p (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (port_p_pin_in),
        .sync_out (p_sync)
    );
    pin_sync #(
        .WIDTH    (`PORT_L_WIDTH)
    ) u_sync_l (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (port_l_pin_in),
        .sync_out (l_sync)
    );
    pin_sync #(
        .WIDTH    (`PORT_AD_WIDTH)
    ) u_sync_ad (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (port_ad_pin_in),
        .sync_out (ad_sync)
    );

    // Port S output priority chains
    always_comb begin
        next_s_out = gpio_ctrl.port_s_data;
        next_s_oe  = gpio_ctrl.port_s_dir;
        // Pin 5 and 4: SPI select and clock over port
        if (periph_out.spi_ss_en) begin
            next_s_out[5] = periph_out.spi_ss_out;
            next_s_oe[5]  = 1'b1;
        end
        if (periph_out.spi_sck_en) begin
            next_s_out[4] = periph_out.spi_sck_out;
            next_s_oe[4]  = 1'b1;
        end
        // Pin 3
        if (periph_out.free_running_clock_out_en) begin
            next_s_out[3] = periph_out.free_running_clock_out;
            next_s_oe[3]  = 1'b1;
        end else if (periph_out.spi_mosi_en) begin
            next_s_out[3] = periph_out.spi_mosi_out;
            next_s_oe[3]  = 1'b1;
        end else if (routing.serial_if1_to_s3_s2 && periph_out.serial_if1_transmit_en) begin
            next_s_out[3] = periph_out.serial_if1_transmit;
            next_s_oe[3]  = 1'b1;
        end else if (routing.pulse_width_channel_5_to_s3 && periph_out.pwm_en[5]) begin
            next_s_out[3] = periph_out.pwm_out[5];
            next_s_oe[3]  = 1'b1;
        end else if (routing.trig1_from_s3) begin
            next_s_oe[3]  = 1'b0;
        end
        // Pin 2
        if (periph_out.spi_miso_en) begin
            next_s_out[2] = periph_out.spi_miso_out;
            next_s_oe[2]  = 1'b1;
        end else if (routing.serial_if1_to_s3_s2) begin
            next_s_oe[2]  = 1'b0;
        end else if (routing.pulse_width_channel_4_to_s2 && periph_out.pwm_en[4]) begin
            next_s_out[2] = periph_out.pwm_out[4];
            next_s_oe[2]  = 1'b1;
        end else if (routing.trig0_from_s2) begin
            next_s_oe[2]  = 1'b0;
        end
        // Pin 1
        if (!routing.serial_if1_to_s3_s2 && periph_out.serial_if1_transmit_en) begin
            next_s_out[1] = periph_out.serial_if1_transmit;
            next_s_oe[1]  = 1'b1;
        end else if (routing.lin_bit_to_s1) begin
            next_s_out[1] = periph_out.lin_transceiver_reg_bit_out;
            next_s_oe[1]  = 1'b1;
        end else if (routing.serial_if0_to_s1_s0) begin
            next_s_out[1] = periph_out.serial_if0_transmit;
            next_s_oe[1]  = 1'b1;
        end
        // Pin 0 is receive when a serial interface owns it
        if (!routing.serial_if1_to_s3_s2 || routing.serial_if0_to_s1_s0) begin
            next_s_oe[0] = 1'b0;
        end
    end

    // Port P output priority chains
    always_comb begin
        next_p_out = gpio_ctrl.port_p_data;
        next_p_oe  = gpio_ctrl.port_p_dir;
        // Pin 5: interrupt input ahead of PWM 5
        if (periph_out.irq_enable) begin
            next_p_oe[5] = 1'b0;
        end else if (!routing.pulse_width_channel_5_to_s3 && periph_out.pwm_en[5]) begin
            next_p_out[5] = periph_out.pwm_out[5];
            next_p_oe[5]  = 1'b1;
        end
        // Pin 4
        if (!routing.pulse_width_channel_4_to_s2 && periph_out.pwm_en[4]) begin
            next_p_out[4] = periph_out.pwm_out[4];
            next_p_oe[4]  = 1'b1;
        end
        // Pin 3
        if (periph_out.pwm_en[3]) begin
            next_p_out[3] = periph_out.pwm_out[3];
            next_p_oe[3]  = 1'b1;
        end
        // Pin 2: PWM 2, else supply switch, else port
        if (periph_out.pwm_en[2]) begin
            next_p_out[2] = periph_out.pwm_out[2];
            next_p_oe[2]  = 1'b1;
        end else if (periph_out.switchable_supply_out_en) begin
            next_p_out[2] = 1'b1;
            next_p_oe[2]  = 1'b1;
        end
        // Pin 1: nonmaskable interrupt ahead of PWM 1
        if (periph_out.nonmaskable_interrupt_en) begin
            next_p_oe[1] = 1'b0;
        end else if (periph_out.pwm_en[1]) begin
            next_p_out[1] = periph_out.pwm_out[1];
            next_p_oe[1]  = 1'b1;
        end
        // Pin 0
        if (periph_out.pwm_en[0]) begin
            next_p_out[0] = periph_out.pwm_out[0];
            next_p_oe[0]  = 1'b1;
        end
    end

    // Registered port S and P drivers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            port_s_pin_out <= `PORT_RESET_VALUE;
            port_s_pin_oe  <= `PORT_RESET_VALUE;
            port_p_pin_out <= `PORT_RESET_VALUE;
            port_p_pin_oe  <= `PORT_RESET_VALUE;
        end else begin
            port_s_pin_out <= next_s_out;
            port_s_pin_oe  <= next_s_oe;
            port_p_pin_out <= next_p_out;
            port_p_pin_oe  <= next_p_oe;
        end
    end

    // Port AD: analog selection beats port drive
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            port_ad_pin_out       <= `PORT_RESET_VALUE;
            port_ad_pin_oe        <= `PORT_RESET_VALUE;
            analog_channel_in_sel <= `PORT_RESET_VALUE;
        end else begin
            port_ad_pin_out       <= gpio_ctrl.port_ad_data;
            port_ad_pin_oe        <= gpio_ctrl.port_ad_dir & ~gpio_ctrl.analog_channel_en;
            analog_channel_in_sel <= gpio_ctrl.analog_channel_en;
        end
    end

    // Inputs returned to peripherals
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            periph_in <= '0;
        end else begin
            periph_in.serial_if1_receive <= routing.serial_if1_to_s3_s2 ? s_sync[2]
                                                                         : s_sync[0];
            periph_in.serial_if0_receive <= routing.serial_if0_to_s1_s0 ? s_sync[0]
                                                                         : 1'b1;
            periph_in.spi_miso_in        <= s_sync[2];
            periph_in.spi_mosi_in        <= s_sync[3];
            periph_in.spi_sck_in         <= s_sync[4];
            periph_in.spi_ss_in          <= s_sync[5];
            periph_in.adc_trigger_in_0   <= routing.trig0_from_s2 ? s_sync[2] : p_sync[4];
            periph_in.adc_trigger_in_1   <= routing.trig1_from_s3 ? s_sync[3] : p_sync[5];
            periph_in.irq_in             <= periph_out.irq_enable ? p_sync[5] : 1'b1;
            periph_in.nonmaskable_interrupt_in <= p_sync[1];
            periph_in.port_s_gpio        <= s_sync;
            periph_in.port_p_gpio        <= p_sync;
            periph_in.port_l_gpio        <= l_sync;
            periph_in.port_ad_gpio       <= ad_sync;
            periph_in.high_voltage_input_adc <= l_sync & routing.port_l_adc_link;
        end
    end
endmodule

/* File: pin_mux_monitor.sv */
// Checker for the port S, P, L and AD pin multiplexer
`timescale 1ns/10ps
module pin_mux_monitor
    import pin_mux_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire periph_out_t periph_out,
    input wire routing_t    routing,
    input wire gpio_ctrl_t  gpio_ctrl,
    input wire logic [3:0]  port_l_pin_in,
    input wire logic [5:0]  port_s_pin_out,
    input wire logic [5:0]  port_s_pin_oe,
    input wire logic [5:0]  port_p_pin_out,
    input wire logic [5:0]  port_p_pin_oe,
    input wire logic [5:0]  port_ad_pin_oe,
    input wire logic [5:0]  analog_channel_in_sel,
    input wire periph_in_t  periph_in
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Ownership of the checked pins one edge after the request; port L input three edges after the pin
    a_clock_out_first: assert property (
        $past(reset_n) && $past(periph_out.free_running_clock_out_en) |-> port_s_pin_oe[3]
        && port_s_pin_out[3] == $past(periph_out.free_running_clock_out))
        else $error("clock out lost pin s3");
    a_mosi_second: assert property (
        $past(reset_n) && $past(periph_out.spi_mosi_en)
        && !$past(periph_out.free_running_clock_out_en)
        |-> port_s_pin_oe[3] && port_s_pin_out[3] == $past(periph_out.spi_mosi_out))
        else $error("mosi lost pin s3");
    a_miso_s2_top: assert property (
        $past(reset_n) && $past(periph_out.spi_miso_en)
        |-> port_s_pin_oe[2] && port_s_pin_out[2] == $past(periph_out.spi_miso_out))
        else $error("miso lost pin s2");
    a_s1_transmit_top: assert property (
        $past(reset_n) && $past(periph_out.serial_if1_transmit_en)
        && !$past(routing.serial_if1_to_s3_s2) |-> port_s_pin_oe[1]
        && port_s_pin_out[1] == $past(periph_out.serial_if1_transmit))
        else $error("transmit 1 lost pin s1");
    a_irq_holds_p5: assert property (
        $past(reset_n) && $past(periph_out.irq_enable) |-> !port_p_pin_oe[5])
        else $error("p5 driven while interrupt input");
    a_nmi_holds_p1: assert property (
        $past(reset_n) && $past(periph_out.nonmaskable_interrupt_en) |-> !port_p_pin_oe[1])
        else $error("p1 driven while nmi input");
    a_pwm0_owns_p0: assert property (
        $past(reset_n) && $past(periph_out.pwm_en[0])
        |-> port_p_pin_oe[0] && port_p_pin_out[0] == $past(periph_out.pwm_out[0]))
        else $error("pwm 0 lost pin p0");
    a_analog_beats_gpio: assert property (
        $past(reset_n) |-> analog_channel_in_sel == $past(gpio_ctrl.analog_channel_en)
        && port_ad_pin_oe == ($past(gpio_ctrl.port_ad_dir) & ~$past(gpio_ctrl.analog_channel_en)))
        else $error("ad drive wrong");
    a_input_three_edges: assert property (
        $past(reset_n) && $past(reset_n, 2) && $past(reset_n, 3)
        |-> periph_in.port_l_gpio == $past(port_l_pin_in, 3))
        else $error("port l input latency wrong");
endmodule

bind port_s_p_l_ad_pin_mux pin_mux_monitor pin_mux_monitor_inst (.clk(clk),
    .reset_n(reset_n), .periph_out(periph_out), .routing(routing), .gpio_ctrl(gpio_ctrl),
    .port_l_pin_in(port_l_pin_in), .port_s_pin_out(port_s_pin_out),
    .port_s_pin_oe(port_s_pin_oe), .port_p_pin_out(port_p_pin_out),
    .port_p_pin_oe(port_p_pin_oe), .port_ad_pin_oe(port_ad_pin_oe),
    .analog_channel_in_sel(analog_channel_in_sel), .periph_in(periph_in));

/* File: pin_world.sv */
// Board-side pin model: driven pins read back, released pins show outside level
`timescale 1ns/10ps
module pin_world (
    input  wire logic [5:0] s_out,
    input  wire logic [5:0] s_oe,
    input  wire logic [5:0] p_out,
    input  wire logic [5:0] p_oe,
    input  wire logic [5:0] ad_out,
    input  wire logic [5:0] ad_oe,
    input  wire logic [5:0] ext_s,
    input  wire logic [5:0] ext_p,
    input  wire logic [5:0] ext_ad,
    input  wire logic [3:0] ext_l,
    output logic      [5:0] s_in,
    output logic      [5:0] p_in,
    output logic      [5:0] ad_in,
    output logic      [3:0] l_in
);
    // Wire level per pin from whoever drives it
    assign s_in  = (s_oe & s_out) | (~s_oe & ext_s);
    assign p_in  = (p_oe & p_out) | (~p_oe & ext_p);
    assign ad_in = (ad_oe & ad_out) | (~ad_oe & ext_ad);
    assign l_in  = ext_l;
endmodule

/* File: port_s_p_l_ad_pin_mux_test.sv */
// Self-checking bench for the port S, P, L and AD pin multiplexer
`timescale 1ns/10ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    mismatches++; $display("BAD %s exp %h got %h", what, exp, got); end end
module port_s_p_l_ad_pin_mux_test
    import pin_mux_pkg::*;
;
    logic        clk, reset_n;
    periph_out_t po;
    routing_t    rt;
    gpio_ctrl_t  gc;
    periph_in_t  pi;
    logic [5:0]  s_in, s_out, s_oe, p_in, p_out, p_oe, ad_in, ad_out, ad_oe, sel;
    logic [5:0]  ext_s, ext_p, ext_ad;
    logic [3:0]  ext_l, l_in;
    int          mismatches, samples_checked;

    port_s_p_l_ad_pin_mux port_s_p_l_ad_pin_mux_inst (.clk(clk), .reset_n(reset_n),
        .periph_out(po), .routing(rt), .gpio_ctrl(gc), .port_s_pin_in(s_in),
        .port_p_pin_in(p_in), .port_l_pin_in(l_in), .port_ad_pin_in(ad_in),
        .port_s_pin_out(s_out), .port_s_pin_oe(s_oe), .port_p_pin_out(p_out),
        .port_p_pin_oe(p_oe), .port_ad_pin_out(ad_out), .port_ad_pin_oe(ad_oe),
        .analog_channel_in_sel(sel), .periph_in(pi));
    pin_world pin_world_inst (.s_out(s_out), .s_oe(s_oe), .p_out(p_out), .p_oe(p_oe),
        .ad_out(ad_out), .ad_oe(ad_oe), .ext_s(ext_s), .ext_p(ext_p), .ext_ad(ext_ad),
        .ext_l(ext_l), .s_in(s_in), .p_in(p_in), .ad_in(ad_in), .l_in(l_in));

    // Clock source
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Let one edge register the request and show it; the second edge is spare margin
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Port S pin 3 fall-through: each owner dropped in turn
    task t_s3_chain;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            po.free_running_clock_out_en <= (i < 1);
            po.spi_mosi_en               <= (i < 2);
            rt.serial_if1_to_s3_s2       <= (i < 3);
            rt.pulse_width_channel_5_to_s3 <= (i < 4);
            po.pwm_en[5]                 <= 1'b1;
            settle();
            `CHK("s3 oe", 1'b1, s_oe[3])
            `CHK("s3 out", i[0] ? 1'b0 : 1'b1, s_out[3])
            `CHK("p5 pwm when routed", i < 4 ? 1'b0 : 1'b1, p_oe[5])
        end
        @(posedge clk);
        rt.trig1_from_s3 <= 1'b1;
        settle();
        `CHK("s3 trigger input", 1'b0, s_oe[3])
        $display("done s3 chain");
    endtask

    // Port S pin 1 fall-through and pin 2 master-in
    task t_s1_chain;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            po.serial_if1_transmit_en <= (i < 1);
            rt.lin_bit_to_s1          <= (i < 2);
            rt.serial_if0_to_s1_s0    <= (i < 3);
            po.spi_miso_en            <= (i == 0);
            po.serial_if1_transmit    <= 1'b0;
            rt.trig0_from_s2          <= (i != 1);
            settle();
            `CHK("s1 out", i[0] ? 1'b1 : 1'b0, s_out[1])
            `CHK("s2 oe", i < 2 ? 1'b1 : 1'b0, s_oe[2])
            `CHK("s2 out", i == 0 ? 1'b0 : 1'b1, s_out[2])
        end
        $display("done s1 chain");
    endtask

    // Port P: interrupt inputs hold pins, pwm and supply own the rest
    task t_port_p;
        @(posedge clk);
        po.pwm_en <= 6'h3f;
        po.irq_enable <= 1'b1;
        po.nonmaskable_interrupt_en <= 1'b1;
        po.spi_sck_en <= 1'b1;
        settle();
        `CHK("s4 sck", 2'b10, {s_oe[4], s_out[4]})
        `CHK("p oe", 6'h1d, p_oe)
        `CHK("p out", 6'h05, p_out & 6'h1d)
        @(posedge clk);
        po.pwm_en <= 6'h00;
        po.irq_enable <= 1'b0;
        po.nonmaskable_interrupt_en <= 1'b0;
        po.spi_sck_en <= 1'b0;
        settle();
        `CHK("p2 supply", 2'b11, {p_oe[2], p_out[2]})
        `CHK("p gpio oe", 6'h04, p_oe)
        $display("done port p");
    endtask

    // Inputs, analog selection and receive routing
    task t_inputs;
        @(posedge clk);
        ext_l <= 4'ha;
        ext_s <= 6'h3e;
        gc.analog_channel_en <= 6'h03;
        rt.serial_if0_to_s1_s0 <= 1'b1;
        rt.port_l_adc_link <= 4'h6;
        repeat (4) @(posedge clk);
        #1;
        `CHK("l inputs", 4'ha, pi.port_l_gpio)
        `CHK("l adc link", 4'h2, pi.high_voltage_input_adc)
        `CHK("analog sel", 6'h03, sel)
        `CHK("ad oe", 6'h3c, ad_oe)
        `CHK("ad out", 6'h2a, ad_out)
        `CHK("ad readback", 6'h29, pi.port_ad_gpio)
        `CHK("s readback", 6'h3c, pi.port_s_gpio)
        `CHK("p readback", 6'h2e, pi.port_p_gpio)
        `CHK("receive 0", 1'b0, pi.serial_if0_receive)
        `CHK("receive 1", 1'b0, pi.serial_if1_receive)
        `CHK("trigger 0 routed", 1'b1, pi.adc_trigger_in_0)
        $display("done inputs");
    endtask

    // Verdict
    task summarize;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog
    initial begin
        #4000;
        mismatches++;
        summarize();
    end

    // Main sequence
    initial begin
        reset_n = 1'b0;
        po = '0;
        rt = '0;
        gc = '0;
        ext_s = 6'h15;
        ext_p = 6'h2a;
        ext_ad = 6'h15;
        ext_l = 4'h5;
        mismatches = 0;
        samples_checked = 0;
        po.free_running_clock_out = 1'b1;
        po.serial_if1_transmit = 1'b1;
        po.serial_if1_transmit_en = 1'b1;
        po.lin_transceiver_reg_bit_out = 1'b1;
        po.pwm_out = 6'h05;
        po.switchable_supply_out_en = 1'b1;
        gc.port_s_data = 6'h3f;
        gc.port_s_dir = 6'h3f;
        gc.port_ad_data = 6'h2a;
        gc.port_ad_dir = 6'h3f;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        `CHK("reset oe", 18'h0, {s_oe, p_oe, ad_oe})
        t_s3_chain();
        t_s1_chain();
        t_port_p();
        t_inputs();
        summarize();
    end
endmodule
